// ### rtl/ccirq_map.svh
// ccirq_map.svh: register offsets, field positions and reset values
`ifndef CCIRQ_MAP_SVH
`define CCIRQ_MAP_SVH
`define CCIRQ_ADDR_W 8
`define CCIRQ_CTRL_OFF 8'h00
`define CCIRQ_RAW_OFF 8'h08
`define CCIRQ_EN_OFF 8'h0C
`define CCIRQ_MASKED_OFF 8'h10
`define CCIRQ_CLR_OFF 8'h14
`define CCIRQ_CODES_OFF 8'h18
`define CCIRQ_UNMASK_OFF 8'h1C
`define CCIRQ_SEL_CTRL 0
`define CCIRQ_SEL_RAW 1
`define CCIRQ_SEL_EN 2
`define CCIRQ_SEL_MASKED 3
`define CCIRQ_SEL_CLR 4
`define CCIRQ_SEL_CODES 5
`define CCIRQ_SEL_UNMASK 6
`define CCIRQ_NSEL 7
`define CCIRQ_EV_W 5
`define CCIRQ_EV_DONE 0
`define CCIRQ_EV_OVR 1
`define CCIRQ_EV_SERR 2
`define CCIRQ_EV_FRAME 3
`define CCIRQ_EV_ROW 4
`define CCIRQ_INBAND_BIT 4
`define CCIRQ_ROWLVL_BIT 6
`define CCIRQ_FRMLVL_BIT 7
`define CCIRQ_CTRL_WMASK 32'h0000_00D0
`define CCIRQ_RST32 32'h0000_0000
`define CCIRQ_LEAD_FF 8'hFF
`define CCIRQ_LEAD_00 8'h00
`define CCIRQ_RESP_OKAY 2'b00
`define CCIRQ_RESP_SLVERR 2'b10
`endif

// ### rtl/ccirq_pkg.sv
// ccirq_pkg: state types of the capture event block
package ccirq_pkg;
    typedef enum logic [2:0] {
        SEQ_OUT = 3'b001,
        SEQ_FRAME = 3'b010,
        SEQ_ROW = 3'b100
    } ccirq_seq_t;
    typedef enum logic [3:0] {
        HUNT_FF = 4'b0001,
        HUNT_Z1 = 4'b0010,
        HUNT_Z2 = 4'b0100,
        HUNT_CODE = 4'b1000
    } ccirq_hunt_t;
endpackage

// ### rtl/ccirq_sync2.sv
// ccirq_sync2: two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ccirq_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys, // system clock
    input wire logic [W-1:0] d, // asynchronous inputs
    output logic [W-1:0] q // synchronised outputs
);
    logic [W-1:0] meta_reg;

    // no reset: the chain flushes with real pin levels while reset is held,
    // so edge history never sees a forced level jump at release
    always_ff @(posedge clk_sys) begin
        meta_reg <= d;
        q <= meta_reg;
    end
endmodule // ccirq_sync2
`default_nettype wire

// ### rtl/ccirq_delim.sv
// ccirq_delim: finds ff 00 00 xx delimiters in the pixel byte stream
`timescale 1ns/1ps
`default_nettype none
`include "ccirq_map.svh"
module ccirq_delim (
    input wire logic clk_sys, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic byteStb, // pixel byte taken this cycle
    input wire logic [7:0] byteIn, // pixel byte
    input wire logic [31:0] codes, // four programmed code bytes
    input wire logic [31:0] unmask, // per-bit compare enables
    output logic [3:0] hitReg // one-cycle hit per code lane
);
    ccirq_pkg::ccirq_hunt_t huntReg;
    ccirq_pkg::ccirq_hunt_t huntNext;
    logic [3:0] laneHit;
    logic isLead;
    logic isZero;

    function automatic logic codeMatch(input logic [7:0] b,
                                       input logic [7:0] code,
                                       input logic [7:0] um);
        codeMatch = ((b ^ code) & um) == 8'h00;
    endfunction

    assign isLead = byteIn == `CCIRQ_LEAD_FF;
    assign isZero = byteIn == `CCIRQ_LEAD_00;

    for (genvar i = 0; i < 4; i++) begin : g_lane
        // masked bits never take part in the compare
        assign laneHit[i] = codeMatch(byteIn, codes[8*i+:8],
                                      unmask[8*i+:8]);
    end

    always_comb begin
        huntNext = huntReg;
        if (byteStb) begin
            unique case (huntReg)
                ccirq_pkg::HUNT_FF: begin
                    huntNext = isLead ? ccirq_pkg::HUNT_Z1
                                      : ccirq_pkg::HUNT_FF;
                end
                ccirq_pkg::HUNT_Z1: begin
                    huntNext = isZero ? ccirq_pkg::HUNT_Z2 :
                               isLead ? ccirq_pkg::HUNT_Z1 :
                                        ccirq_pkg::HUNT_FF;
                end
                ccirq_pkg::HUNT_Z2: begin
                    huntNext = isZero ? ccirq_pkg::HUNT_CODE :
                               isLead ? ccirq_pkg::HUNT_Z1 :
                                        ccirq_pkg::HUNT_FF;
                end
                ccirq_pkg::HUNT_CODE: begin
                    huntNext = ccirq_pkg::HUNT_FF;
                end
                default: begin
                    huntNext = ccirq_pkg::HUNT_FF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            huntReg <= ccirq_pkg::HUNT_FF;
            hitReg <= 4'h0;
        end else begin
            huntReg <= huntNext;
            hitReg <= (byteStb && huntReg == ccirq_pkg::HUNT_CODE)
                      ? laneHit : 4'h0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence sHeaderDone;
        huntReg == ccirq_pkg::HUNT_Z2 && byteStb && isZero;
    endsequence

    sequence sCodeByte;
        huntReg == ccirq_pkg::HUNT_CODE && byteStb;
    endsequence

    chk_header_walk: assert property (
        sHeaderDone |=> huntReg == ccirq_pkg::HUNT_CODE)
        else $error("delimiter header not followed by code hunt");

    chk_lane_compare: assert property (
        sCodeByte |=> hitReg[0] == $past(codeMatch(byteIn, codes[7:0],
                                                   unmask[7:0])))
        else $error("frame start compare wrong under unmask");
endmodule // ccirq_delim
`default_nettype wire

// ### rtl/ccirq_top.sv
// ccirq_top: capture event flags, interrupt and sync-code registers
`timescale 1ns/1ps
`default_nettype none
`include "ccirq_map.svh"
module ccirq_top (
    input wire logic clk_sys, // system clock, 40 MHz
    input wire logic resetn, // synchronous reset, active low
    input wire logic [`CCIRQ_ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [`CCIRQ_ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic pixClk, // sensor pixel clock pin
    input wire logic frameSyncPin, // sensor frame sync pin
    input wire logic rowSyncPin, // sensor row sync pin
    input wire logic [7:0] pixData, // sensor pixel data pins
    input wire logic overrunEvent, // capture path overrun pulse
    output logic irq // interrupt request, active high
);
    logic [10:0] pinSync;
    logic pixClkS;
    logic frameS;
    logic rowS;
    logic [7:0] dataS;
    logic pixClkPrev;
    logic frameActPrev;
    logic rowActPrev;
    logic pixRise;
    logic frameAct;
    logic rowAct;
    logic [3:0] hit;
    logic pickFs;
    logic pickLs;
    logic pickLe;
    logic pickFe;
    logic codeHit;
    logic legal;
    ccirq_pkg::ccirq_seq_t seqReg;
    ccirq_pkg::ccirq_seq_t seqNext;
    logic fsRise;
    logic rowRise;
    logic frameDone;
    logic syncErr;
    logic [`CCIRQ_EV_W-1:0] ev;
    logic [`CCIRQ_EV_W-1:0] clrMask;
    logic [`CCIRQ_EV_W-1:0] raw_reg;
    logic [`CCIRQ_EV_W-1:0] raw_next;
    logic [`CCIRQ_EV_W-1:0] en_reg;
    logic [`CCIRQ_EV_W-1:0] masked;
    logic [31:0] ctrl_reg;
    logic [31:0] codes_reg;
    logic [31:0] unmask_reg;
    logic inbandSel;
    logic [`CCIRQ_ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic wrFire;
    logic [`CCIRQ_NSEL-1:0] wrSel;
    logic [`CCIRQ_NSEL-1:0] rdSel;
    logic rdTake;
    logic [31:0] rdMux;

    function automatic logic [`CCIRQ_NSEL-1:0] regSel(
        input logic [`CCIRQ_ADDR_W-1:0] a);
        regSel = {a == `CCIRQ_UNMASK_OFF, a == `CCIRQ_CODES_OFF,
                  a == `CCIRQ_CLR_OFF, a == `CCIRQ_MASKED_OFF,
                  a == `CCIRQ_EN_OFF, a == `CCIRQ_RAW_OFF,
                  a == `CCIRQ_CTRL_OFF};
    endfunction

    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            laneMerge[8*i+:8] = strb[i] ? nw[8*i+:8] : old[8*i+:8];
        end
    endfunction

    // pins and the pixel clock are sampled on clk_sys
    ccirq_sync2 #(.W(11)) u_sync (
        .clk_sys(clk_sys),
        .d({pixClk, frameSyncPin, rowSyncPin, pixData}),
        .q(pinSync)
    );

    assign {pixClkS, frameS, rowS, dataS} = pinSync;
    assign pixRise = pixClkS & ~pixClkPrev;
    assign inbandSel = ctrl_reg[`CCIRQ_INBAND_BIT];
    assign frameAct = frameS == ctrl_reg[`CCIRQ_FRMLVL_BIT];
    assign rowAct = rowS == ctrl_reg[`CCIRQ_ROWLVL_BIT];

    ccirq_delim u_delim (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .byteStb(pixRise & inbandSel),
        .byteIn(dataS),
        .codes(codes_reg),
        .unmask(unmask_reg),
        .hitReg(hit)
    );

    // simultaneous matches under wide masks: start codes win
    assign pickFs = hit[0];
    assign pickLs = hit[1] & ~hit[0];
    assign pickLe = hit[2] & ~|hit[1:0];
    assign pickFe = hit[3] & ~|hit[2:0];
    assign codeHit = |hit;

    always_comb begin
        unique case (seqReg)
            ccirq_pkg::SEQ_OUT: legal = pickFs;
            ccirq_pkg::SEQ_FRAME: legal = pickLs | pickFe;
            ccirq_pkg::SEQ_ROW: legal = pickLe;
            default: legal = 1'b0;
        endcase
    end

    // out-of-order codes still move the tracker, so it resyncs
    assign seqNext = pickFs ? ccirq_pkg::SEQ_FRAME :
                     pickLs ? ccirq_pkg::SEQ_ROW :
                     pickLe ? ccirq_pkg::SEQ_FRAME :
                     pickFe ? ccirq_pkg::SEQ_OUT : seqReg;

    assign syncErr = inbandSel & codeHit & ~legal;
    assign fsRise = inbandSel ? pickFs
                              : frameAct & ~frameActPrev;
    assign rowRise = inbandSel ? pickLs
                               : rowAct & ~rowActPrev;
    assign frameDone = inbandSel ? pickFe & legal
                                 : ~frameAct & frameActPrev;

    assign ev[`CCIRQ_EV_DONE] = frameDone;
    assign ev[`CCIRQ_EV_OVR] = overrunEvent;
    assign ev[`CCIRQ_EV_SERR] = syncErr;
    assign ev[`CCIRQ_EV_FRAME] = fsRise;
    assign ev[`CCIRQ_EV_ROW] = rowRise;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            // history follows the settled pins, so release gives no edge
            pixClkPrev <= pixClkS;
            frameActPrev <= frameAct;
            rowActPrev <= rowAct;
            seqReg <= ccirq_pkg::SEQ_OUT;
        end else begin
            pixClkPrev <= pixClkS;
            frameActPrev <= frameAct;
            rowActPrev <= rowAct;
            seqReg <= inbandSel ? seqNext : ccirq_pkg::SEQ_OUT;
        end
    end

    // write channel: address and data taken in either order
    assign awready = ~awHeld_reg;
    assign wready = ~wHeld_reg;
    assign wrFire = awHeld_reg & wHeld_reg & ~bvalid;
    assign wrSel = regSel(awAddr_reg);
    assign clrMask = (wrFire && wrSel[`CCIRQ_SEL_CLR] && wStrb_reg[0])
                     ? wData_reg[`CCIRQ_EV_W-1:0] : '0;

    // a new event wins over a clear in the same cycle
    assign raw_next = (raw_reg & ~clrMask) | ev;
    assign masked = raw_reg & en_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= `CCIRQ_RST32;
            wStrb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `CCIRQ_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awAddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
            awHeld_reg <= wrFire ? 1'b0 : awHeld_reg | awvalid;
            wHeld_reg <= wrFire ? 1'b0 : wHeld_reg | wvalid;
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp <= |wrSel ? `CCIRQ_RESP_OKAY : `CCIRQ_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_reg <= `CCIRQ_RST32;
            en_reg <= '0;
            codes_reg <= `CCIRQ_RST32;
            unmask_reg <= `CCIRQ_RST32;
            raw_reg <= '0;
            irq <= 1'b0;
        end else begin
            if (wrFire && wrSel[`CCIRQ_SEL_CTRL]) begin
                ctrl_reg <= laneMerge(ctrl_reg, wData_reg, wStrb_reg)
                            & `CCIRQ_CTRL_WMASK;
            end
            if (wrFire && wrSel[`CCIRQ_SEL_EN] && wStrb_reg[0]) begin
                en_reg <= wData_reg[`CCIRQ_EV_W-1:0];
            end
            if (wrFire && wrSel[`CCIRQ_SEL_CODES]) begin
                codes_reg <= laneMerge(codes_reg, wData_reg,
                                       wStrb_reg);
            end
            if (wrFire && wrSel[`CCIRQ_SEL_UNMASK]) begin
                unmask_reg <= laneMerge(unmask_reg, wData_reg,
                                        wStrb_reg);
            end
            raw_reg <= raw_next;
            irq <= |masked;
        end
    end

    // read channel: one cycle from address to data
    assign arready = ~rvalid;
    assign rdTake = arvalid & arready;
    assign rdSel = regSel(araddr);
    assign rdMux = rdSel[`CCIRQ_SEL_CTRL] ? ctrl_reg :
                   rdSel[`CCIRQ_SEL_RAW] ? 32'(raw_reg) :
                   rdSel[`CCIRQ_SEL_EN] ? 32'(en_reg) :
                   rdSel[`CCIRQ_SEL_MASKED] ? 32'(masked) :
                   rdSel[`CCIRQ_SEL_CODES] ? codes_reg :
                   rdSel[`CCIRQ_SEL_UNMASK] ? unmask_reg :
                   `CCIRQ_RST32;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata <= `CCIRQ_RST32;
            rresp <= `CCIRQ_RESP_OKAY;
        end else if (rdTake) begin
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= |rdSel ? `CCIRQ_RESP_OKAY : `CCIRQ_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence sClrRow;
        wrFire && wrSel[`CCIRQ_SEL_CLR] && wStrb_reg[0] && wData_reg[4];
    endsequence

    sequence sKeepDone;
        wrFire && wrSel[`CCIRQ_SEL_CLR] && !wData_reg[0] && raw_reg[0];
    endsequence

    chk_done_set: assert property (frameDone |=> raw_reg[0])
        else $error("frame done did not set flag 0");

    chk_ovr_set: assert property (overrunEvent |=> raw_reg[1])
        else $error("overrun did not set flag 1");

    chk_serr_mode: assert property (
        $rose(raw_reg[2]) |-> $past(inbandSel) && $past(codeHit))
        else $error("sync error flag set outside inband mode");

    chk_fsync_set: assert property (
        !inbandSel && frameAct && !frameActPrev |=> raw_reg[3])
        else $error("frame sync rise did not set flag 3");

    chk_rsync_set: assert property (rowRise |=> raw_reg[4])
        else $error("row sync rise did not set flag 4");

    chk_raw_read: assert property (
        rdTake && rdSel[`CCIRQ_SEL_RAW]
        |=> rvalid && rdata == 32'($past(raw_reg)))
        else $error("raw status read wrong");

    chk_en_reset: assert property ($past(!resetn) |-> en_reg == '0)
        else $error("enable register not zero after reset");

    chk_masked_read: assert property (
        rdTake && rdSel[`CCIRQ_SEL_MASKED]
        |=> rdata == 32'($past(raw_reg & en_reg)))
        else $error("masked status read wrong");

    chk_clear_row: assert property (
        sClrRow and !rowRise |=> !raw_reg[4])
        else $error("clear write left flag 4 set");

    chk_codes_reset: assert property (
        $past(!resetn) |-> codes_reg == `CCIRQ_RST32)
        else $error("sync codes not zero after reset");

    chk_zero_keeps: assert property (sKeepDone |=> raw_reg[0])
        else $error("zero clear bit changed flag 0");

    chk_irq_level: assert property (
        irq == $past(|(raw_reg & en_reg)))
        else $error("interrupt line disagrees with masked status");
endmodule // ccirq_top
`default_nettype wire

// ### test/ccirq_sensor_model.sv
// ccirq_sensor_model: image sensor driving pixel clock, syncs and bytes
`timescale 1ns/1ps
`default_nettype none
module ccirq_sensor_model (
    output logic pixClk, // pixel clock, still between bytes
    output logic frameSyncPin, // frame sync level
    output logic rowSyncPin, // row sync level
    output logic [7:0] pixData // pixel byte
);
    initial begin
        pixClk = 1'b0;
        frameSyncPin = 1'b1;
        rowSyncPin = 1'b1;
        pixData = 8'h5A;
    end
    task automatic put_byte(input logic [7:0] b);
        pixData = b;
        #100 pixClk = 1'b1;
        #100 pixClk = 1'b0;
        // hold time over: stale data must not look valid
        pixData = ~b;
    endtask
    task automatic delim(input logic [7:0] code);
        put_byte(8'hFF);
        put_byte(8'h00);
        put_byte(8'h00);
        put_byte(code);
        #400;
    endtask
    task automatic set_frame(input logic v);
        frameSyncPin = v;
        #400;
    endtask
    task automatic set_row(input logic v);
        rowSyncPin = v;
        #400;
    endtask
endmodule // ccirq_sensor_model
`default_nettype wire

// ### test/camera_capture_irq_sync_code_tb.sv
// camera_capture_irq_sync_code_tb: register and event scenarios
`timescale 1ns/1ps
`default_nettype none
`include "ccirq_map.svh"
module camera_capture_irq_sync_code_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic overrunEvent = 1'b0;
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic irq;
    logic pixClk;
    logic frameSyncPin;
    logic rowSyncPin;
    logic [7:0] pixData;
    int numErrors = 0;
    int nCompared = 0;
    int cycles = 0;
    logic [31:0] rd_d;
    logic [1:0] rsp;

    always #12.5 clk_sys = ~clk_sys;

    ccirq_sensor_model sensor (.pixClk(pixClk), .frameSyncPin(frameSyncPin),
        .rowSyncPin(rowSyncPin), .pixData(pixData));

    ccirq_top uut (.clk_sys(clk_sys), .resetn(resetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pixClk(pixClk),
        .frameSyncPin(frameSyncPin), .rowSyncPin(rowSyncPin),
        .pixData(pixData), .overrunEvent(overrunEvent), .irq(irq));

    task automatic wrapUp();
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            numErrors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("write response", {30'h0, `CCIRQ_RESP_OKAY}, {30'h0, r});
    endtask

    // reads a register and compares the bits selected by m
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string n);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(n, e, d & m);
        chk("read response", {30'h0, `CCIRQ_RESP_OKAY}, {30'h0, r});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            wrapUp();
        end
    end

    initial begin
        idle(12);
        resetn <= 1'b1;
        rd(`CCIRQ_EN_OFF, '1, 32'h0000_0000, "enable reset");
        rd(`CCIRQ_CODES_OFF, '1, 32'h0000_0000, "codes reset");
        rd(`CCIRQ_MASKED_OFF, '1, 32'h0000_0000, "masked reset");
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0000, "raw reset");
        wr(`CCIRQ_CTRL_OFF, 32'hFFFF_FFFF);
        rd(`CCIRQ_CTRL_OFF, '1, 32'h0000_00D0, "control bits");
        wr(`CCIRQ_CTRL_OFF, 32'h0000_0000);
        wr(`CCIRQ_CLR_OFF, 32'h0000_001F);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0000, "raw after clear");
        wr(`CCIRQ_EN_OFF, 32'hFFFF_FFFF);
        rd(`CCIRQ_EN_OFF, '1, 32'h0000_001F, "enable bits");
        wr(`CCIRQ_CODES_OFF, 32'h9DB6_55AB);
        rd(`CCIRQ_CODES_OFF, '1, 32'h9DB6_55AB, "codes");
        wstrb <= 4'h2;
        wr(`CCIRQ_CODES_OFF, 32'h1122_8044);
        wstrb <= 4'hF;
        rd(`CCIRQ_CODES_OFF, '1, 32'h9DB6_80AB, "codes lane");
        wr(`CCIRQ_RAW_OFF, 32'hFFFF_FFFF);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0000, "raw read only");
        axr(8'h04, rd_d, rsp);
        chk("unmapped resp", {30'h0, `CCIRQ_RESP_SLVERR}, {30'h0, rsp});
        chk("unmapped data", 32'h0000_0000, rd_d);
        axw(8'h04, 32'hFFFF_FFFF, rsp);
        chk("unmapped wr resp", {30'h0, `CCIRQ_RESP_SLVERR}, {30'h0, rsp});
        // pin sync, both syncs active low
        sensor.set_frame(1'b0);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0008, "frame rise");
        rd(`CCIRQ_MASKED_OFF, '1, 32'h0000_0008, "masked frame");
        chk("irq set", 32'h0000_0001, {31'h0, irq});
        wr(`CCIRQ_CLR_OFF, 32'h0000_0000);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0008, "clear zero");
        wr(`CCIRQ_CLR_OFF, 32'hFFFF_FFE0);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0008, "clear reserved");
        wstrb <= 4'hE;
        wr(`CCIRQ_CLR_OFF, 32'h0000_0008);
        wstrb <= 4'hF;
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0008, "clear lane off");
        wr(`CCIRQ_CLR_OFF, 32'h0000_0008);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0000, "clear one");
        chk("irq clear", 32'h0000_0000, {31'h0, irq});
        sensor.set_row(1'b0);
        sensor.set_row(1'b1);
        sensor.set_frame(1'b1);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0011, "row rise, done");
        // both syncs active high: high to low to high
        wr(`CCIRQ_CTRL_OFF, 32'h0000_00C0);
        wr(`CCIRQ_CLR_OFF, 32'h0000_001F);
        sensor.set_frame(1'b0);
        sensor.set_frame(1'b1);
        sensor.set_row(1'b0);
        sensor.set_row(1'b1);
        rd(`CCIRQ_RAW_OFF, 32'h18, 32'h0000_0018, "sync level");
        // overrun with its enable off
        wr(`CCIRQ_CLR_OFF, 32'h0000_001F);
        wr(`CCIRQ_EN_OFF, 32'h0000_001D);
        overrunEvent <= 1'b1;
        idle(1);
        overrunEvent <= 1'b0;
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0002, "overrun");
        rd(`CCIRQ_MASKED_OFF, '1, 32'h0000_0000, "overrun masked");
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        // inband delimiters, full compare
        wr(`CCIRQ_CTRL_OFF, 32'h0000_0010);
        wr(`CCIRQ_UNMASK_OFF, 32'hFFFF_FFFF);
        rd(`CCIRQ_UNMASK_OFF, '1, 32'hFFFF_FFFF, "unmask");
        wr(`CCIRQ_CLR_OFF, 32'h0000_001F);
        sensor.delim(8'hAB);
        sensor.delim(8'h80);
        sensor.delim(8'hB6);
        sensor.delim(8'h9D);
        rd(`CCIRQ_RAW_OFF, '1, 32'h0000_0019, "inband frame");
        wr(`CCIRQ_CLR_OFF, 32'h0000_001F);
        sensor.delim(8'hB6);
        rd(`CCIRQ_RAW_OFF, 32'h7, 32'h0000_0004, "order error");
        sensor.delim(8'h9D);
        // low nibble of frame start left out of the compare
        wr(`CCIRQ_UNMASK_OFF, 32'hFFFF_FFF0);
        wr(`CCIRQ_CLR_OFF, 32'h0000_001F);
        sensor.delim(8'hA5);
        sensor.delim(8'h9D);
        rd(`CCIRQ_RAW_OFF, 32'h7, 32'h0000_0001, "partial compare");
        wrapUp();
    end
endmodule // camera_capture_irq_sync_code_tb
`default_nettype wire
